// ===== core/sfbi_pkg.sv
// Shared constants and types of the serial flash bus front end
package sfbi_pkg;

  // ==========================================================
  // Opcodes recognised at the link
  localparam logic [7:0] OP_RD_LEGACY = 8'hE8;
  localparam logic [7:0] OP_RD_STD    = 8'h0B;
  localparam logic [7:0] OP_RD_SLOW   = 8'h03;
  localparam logic [7:0] OP_PAGE_RD   = 8'hD2;
  localparam logic [7:0] OP_BUF_RD    = 8'hD4;
  localparam logic [7:0] OP_BUF_SLOW  = 8'hD1;
  localparam logic [7:0] OP_PROT_RD   = 8'h32;
  localparam logic [7:0] OP_LOCK_RD   = 8'h35;
  localparam logic [7:0] OP_SEC_RD    = 8'h77;
  localparam logic [7:0] OP_STAT_RD   = 8'hD7;
  localparam logic [7:0] OP_ID_RD     = 8'h9F;

  // ==========================================================
  // Link timing and framing
  localparam int unsigned SCK_MAX_MHZ = 66;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [3:0]  ADDR_LAST   = 4'h3;
  // Header lengths in bytes, opcode included
  localparam logic [3:0]  HDR_LONG    = 4'h8;
  localparam logic [3:0]  HDR_MID     = 4'h5;
  localparam logic [3:0]  HDR_SHORT   = 4'h4;
  localparam logic [3:0]  HDR_OPONLY  = 4'h1;

  // ==========================================================
  // Page geometry
  localparam logic [8:0] PAGE_LAST_STD = 9'h0FF;
  localparam logic [8:0] PAGE_LAST_EXT = 9'h107;
  localparam int unsigned PAGE_DEPTH   = 264;
  localparam int unsigned REG_DEPTH    = 256;
  localparam logic [8:0] PTR_RST       = 9'h000;
  localparam logic [8:0] ID_LEN        = 9'h004;

  // ==========================================================
  // Register image bases inside the register memory
  localparam logic [1:0] PROT_BASE = 2'h0;
  localparam logic [1:0] LOCK_BASE = 2'h1;
  localparam logic       SEC_BASE  = 1'h1;

  // ==========================================================
  // Reset and idle values
  localparam logic [7:0]  SO_IDLE_BYTE = 8'hFF;
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [23:0] ADDR_RST     = 24'h000000;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    CL_NONE   = 4'h0,
    CL_ARRAY  = 4'h1,
    CL_PAGE   = 4'h2,
    CL_BUFFER = 4'h3,
    CL_PROT   = 4'h4,
    CL_LOCK   = 4'h5,
    CL_SEC    = 4'h6,
    CL_STATUS = 4'h7,
    CL_ID     = 4'h8
  } sfbi_class_t;

  typedef enum logic [1:0] {
    PH_CMD   = 2'b00,
    PH_ADDR  = 2'b01,
    PH_DUMMY = 2'b11,
    PH_DATA  = 2'b10
  } sfbi_phase_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
  } sfbi_hdr_t;

  typedef struct packed {
    logic        valid;
    sfbi_class_t cls;
    logic [7:0]  opcode;
    logic [8:0]  page;
    logic [8:0]  offset;
  } sfbi_cmd_t;

  typedef struct packed {
    logic       en;
    logic       region;
    logic [8:0] addr;
    logic [7:0] data;
  } sfbi_fill_t;

endpackage : sfbi_pkg

// ===== core/sfbi_xfer.sv
// Toggle handshake carrying one held word from the link clock to CLK
`timescale 1ns/1ps
module sfbi_xfer
  import sfbi_pkg::*;
#(
  parameter int unsigned W = 32
)
(
  // Source side, link clock
  input  wire logic         src_clk,
  input  wire logic         src_clr,
  input  wire logic         src_pulse,
  input  wire logic [W-1:0] src_data,
  // Destination side, system clock
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  output logic              dst_pulse,
  output logic [W-1:0]      dst_data
);

  logic         tog_r;
  logic [W-1:0] hold_r;
  logic [2:0]   sync_r;
  logic         edge_nxt;

  // ==========================================================
  // Source: word held stable until the next event
  always_ff @(posedge src_clk or posedge src_clr)
  begin
    if (src_clr)
      tog_r <= 1'b0;
    else if (src_pulse)
      tog_r <= ~tog_r;
  end

  always_ff @(posedge src_clk or posedge src_clr)
  begin
    if (src_clr)
      hold_r <= '0;
    else if (src_pulse)
      hold_r <= src_data;
  end

  // ==========================================================
  // Destination: only sync_r[1] looks at the first stage
  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
      sync_r <= 3'h0;
    else
      sync_r <= {sync_r[1:0], tog_r};
  end

  assign edge_nxt = sync_r[2] ^ sync_r[1];

  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
      dst_pulse <= 1'b0;
    else
      dst_pulse <= edge_nxt;
  end

  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
      dst_data <= '0;
    else if (edge_nxt)
      dst_data <= hold_r;
  end

endmodule : sfbi_xfer

// ===== core/sfbi_top.sv
// Serial flash link front end: shifter, opcode decode, read streaming
// ==========================================================
// What this block does
// - Launch output on falling, sample input rising.
// - Full-cycle scheme supported up to 66 MHz.
// - Accept clock low or high at select.
// - Compatible forms: output valid in low phase.
// - Full-cycle forms: output valid by next fall.
// - Whole input header first, then output bytes.
// - Decode E8, 0B, 03 continuous array reads.
// - Decode D2 direct main page read.
// - Decode D4 and D1 buffer reads.
// - Decode 32, 35, 77 register reads.
// - Decode D7 status, 9F identification reads.
// - Address split follows page size 256/264.
`timescale 1ns/1ps
module sfbi_top
  import sfbi_pkg::*;
#(
  // Arbitrary neutral identification bytes, first byte sent first
  parameter logic [31:0] ID_CODE = 32'h5A010200
)
(
  // System clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Serial link, clocked by the host
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic       SI,
  output logic            SO,
  output logic            SO_OE,
  // Core configuration and state
  input  wire logic       PAGE_264,
  input  wire logic [7:0] STATUS,
  // Read image fill port
  input  wire sfbi_fill_t FILL,
  // Decoded command towards the core
  output sfbi_cmd_t       CMD
);

  // ==========================================================
  // Decode helpers
  function automatic sfbi_class_t class_of(input logic [7:0] op);
    case (op)
      OP_RD_LEGACY, OP_RD_STD, OP_RD_SLOW: class_of = CL_ARRAY;
      OP_PAGE_RD:                          class_of = CL_PAGE;
      OP_BUF_RD, OP_BUF_SLOW:              class_of = CL_BUFFER;
      OP_PROT_RD:                          class_of = CL_PROT;
      OP_LOCK_RD:                          class_of = CL_LOCK;
      OP_SEC_RD:                           class_of = CL_SEC;
      OP_STAT_RD:                          class_of = CL_STATUS;
      OP_ID_RD:                            class_of = CL_ID;
      default:                             class_of = CL_NONE;
    endcase
  endfunction : class_of

  function automatic logic [3:0] hdr_len_of(input logic [7:0] op);
    case (op)
      OP_RD_LEGACY, OP_PAGE_RD: hdr_len_of = HDR_LONG;
      OP_RD_STD, OP_BUF_RD:     hdr_len_of = HDR_MID;
      OP_STAT_RD, OP_ID_RD:     hdr_len_of = HDR_OPONLY;
      default:                  hdr_len_of = HDR_SHORT;
    endcase
  endfunction : hdr_len_of

  // byte offset width depends on page size
  function automatic logic [8:0] offset_of(input logic [23:0] a,
                                           input logic        ext);
    offset_of = ext ? a[8:0] : {1'b0, a[7:0]};
  endfunction : offset_of

  // ==========================================================
  // System-side state
  logic [7:0]  page_mem [PAGE_DEPTH];
  logic [7:0]  reg_mem  [REG_DEPTH];
  logic        cfg_264_r;
  logic [7:0]  status_r;
  logic        hdr_pulse;
  sfbi_hdr_t   hdr_sys;
  sfbi_class_t sys_cls;

  // Link-side state
  sfbi_phase_t phase_r;
  sfbi_class_t cls_r;
  logic [2:0]  bit_cnt_r;
  logic [3:0]  byte_cnt_r;
  logic [3:0]  hdr_len_r;
  logic [6:0]  in_sh_r;
  sfbi_hdr_t   hdr_r;
  logic [8:0]  ptr_r;
  logic [7:0]  out_sh_r;
  logic        oe_r;

  logic [7:0]  byte_in;
  logic        byte_done;
  logic        hdr_done;
  sfbi_hdr_t   hdr_now;
  sfbi_class_t cls_now;
  logic [8:0]  page_last;
  logic [7:0]  rd_byte;

  // ==========================================================
  // System clock: image fill, configuration, status
  always_ff @(posedge CLK)
  begin
    if (FILL.en && !FILL.region)
      page_mem[FILL.addr] <= FILL.data;
  end

  always_ff @(posedge CLK)
  begin
    if (FILL.en && FILL.region)
      reg_mem[FILL.addr[7:0]] <= FILL.data;
  end

  // Read by the link side as quasi-static; change only between frames
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cfg_264_r <= 1'b0;
      status_r  <= STATUS_RST;
    end
    else
    begin
      cfg_264_r <= PAGE_264;
      status_r  <= STATUS;
    end
  end

  // ==========================================================
  // Link, rising edge: input shifter
  // most significant bit arrives first
  assign byte_in   = {in_sh_r, SI};
  assign byte_done = (bit_cnt_r == BIT_LAST);
  assign page_last = cfg_264_r ? PAGE_LAST_EXT : PAGE_LAST_STD;

  // no divider, link logic runs straight off SCK
  // input sampled on rising edges only
  // relies on the host launching on rising edges
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      in_sh_r   <= 7'h00;
      bit_cnt_r <= BIT_FIRST;
    end
    else
    begin
      in_sh_r   <= byte_in[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Header assembled as it would stand after this edge
  always_comb
  begin
    hdr_now = hdr_r;
    if (phase_r == PH_CMD)
    begin
      hdr_now.opcode = byte_in;
      hdr_now.addr   = ADDR_RST;
    end
    else if (phase_r == PH_ADDR)
      hdr_now.addr = {hdr_r.addr[15:0], byte_in};
  end

  assign cls_now = (phase_r == PH_CMD) ? class_of(byte_in) : cls_r;

  // header ends on its last input bit, output follows
  always_comb
  begin
    hdr_done = 1'b0;
    if (byte_done)
    begin
      unique case (phase_r)
        PH_CMD:   hdr_done = (hdr_len_of(byte_in) == HDR_OPONLY);
        PH_ADDR:  hdr_done = (byte_cnt_r == ADDR_LAST) &&
                             (hdr_len_r == HDR_SHORT);
        PH_DUMMY: hdr_done = (byte_cnt_r + 4'h1 == hdr_len_r);
        PH_DATA:  hdr_done = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Link, rising edge: command phases
  // select high drops the frame at once
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      phase_r    <= PH_CMD;
      byte_cnt_r <= 4'h0;
    end
    else if (byte_done)
    begin
      unique case (phase_r)
        PH_CMD:
        begin
          byte_cnt_r <= 4'h1;
          phase_r    <= hdr_done ? PH_DATA : PH_ADDR;
        end
        PH_ADDR:
        begin
          byte_cnt_r <= byte_cnt_r + 4'h1;
          if (byte_cnt_r == ADDR_LAST)
            phase_r <= hdr_done ? PH_DATA : PH_DUMMY;
        end
        PH_DUMMY:
        begin
          byte_cnt_r <= byte_cnt_r + 4'h1;
          if (hdr_done)
            phase_r <= PH_DATA;
        end
        PH_DATA:
          phase_r <= PH_DATA;
      endcase
    end
  end

  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      hdr_r     <= '0;
      cls_r     <= CL_NONE;
      hdr_len_r <= HDR_SHORT;
    end
    else if (byte_done && phase_r != PH_DATA)
    begin
      hdr_r <= hdr_now;
      if (phase_r == PH_CMD)
      begin
        cls_r     <= cls_now;
        hdr_len_r <= hdr_len_of(byte_in);
      end
    end
  end

  // Read pointer: loaded at header end, stepped per output byte
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
      ptr_r <= PTR_RST;
    else if (hdr_done)
    begin
      unique case (cls_now)
        CL_ARRAY, CL_PAGE, CL_BUFFER:
          ptr_r <= offset_of(hdr_now.addr, cfg_264_r);
        default:
          ptr_r <= PTR_RST;
      endcase
    end
    else if (byte_done && phase_r == PH_DATA)
    begin
      if (cls_now == CL_ID && ptr_r == ID_LEN)
        ptr_r <= ptr_r;
      else if (ptr_r == page_last)
        ptr_r <= PTR_RST;
      else
        ptr_r <= ptr_r + 9'h001;
    end
  end

  // ==========================================================
  // Outgoing byte source
  always_comb
  begin
    rd_byte = BYTE_ZERO;
    unique case (cls_r)
      CL_ARRAY, CL_PAGE, CL_BUFFER:
        rd_byte = page_mem[ptr_r];
      CL_PROT:
        rd_byte = reg_mem[{PROT_BASE, ptr_r[5:0]}];
      CL_LOCK:
        rd_byte = reg_mem[{LOCK_BASE, ptr_r[5:0]}];
      CL_SEC:
        rd_byte = reg_mem[{SEC_BASE, ptr_r[6:0]}];
      CL_STATUS:
        rd_byte = status_r;
      CL_ID:
        if (ptr_r < ID_LEN)
          rd_byte = ID_CODE[8'(31 - 8 * ptr_r[1:0]) -: 8];
      default:
        rd_byte = BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // Link, falling edge: output shifter
  // an early falling edge in the opcode phase does nothing
  // each output bit is launched on a falling edge
  // SO settles right after the fall, inside the low phase
  // so it is also stable at the host's next falling edge
  always_ff @(negedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      out_sh_r <= SO_IDLE_BYTE;
      oe_r     <= 1'b0;
    end
    else if (phase_r == PH_DATA && cls_r != CL_NONE)
    begin
      oe_r <= 1'b1;
      if (bit_cnt_r == BIT_FIRST)
        out_sh_r <= rd_byte;
      else
        out_sh_r <= {out_sh_r[6:0], 1'b1};
    end
  end

  assign SO = out_sh_r[7];

  // output released as soon as select rises
  assign SO_OE = oe_r & ~CS_N;

  // ==========================================================
  // Header hand-off to the system clock
  // toggle cleared by RST while select stays high
  sfbi_xfer #(
    .W ($bits(sfbi_hdr_t))
  ) u_xfer (
    .src_clk   (SCK),
    .src_clr   (RST),
    .src_pulse (hdr_done),
    .src_data  (hdr_now),
    .dst_clk   (CLK),
    .dst_rst   (RST),
    .dst_pulse (hdr_pulse),
    .dst_data  (hdr_sys)
  );

  assign sys_cls = class_of(hdr_sys.opcode);

  // page and offset split by page size, except status and ID
  always_ff @(posedge CLK)
  begin
    if (RST)
      CMD <= '0;
    else
    begin
      CMD.valid <= hdr_pulse;
      if (hdr_pulse)
      begin
        CMD.cls    <= sys_cls;
        CMD.opcode <= hdr_sys.opcode;
        if (sys_cls == CL_STATUS || sys_cls == CL_ID)
        begin
          CMD.page   <= 9'h000;
          CMD.offset <= 9'h000;
        end
        else
        begin
          CMD.page   <= cfg_264_r ? hdr_sys.addr[17:9]
                                  : hdr_sys.addr[16:8];
          CMD.offset <= offset_of(hdr_sys.addr, cfg_264_r);
        end
      end
    end
  end

endmodule : sfbi_top

// ===== tb/sfbi_props.sv
// Link and command checker bound to the serial flash front end
`timescale 1ns/1ps
module sfbi_props
  import sfbi_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h5A010200
)
(
  // System side
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] STATUS,
  input wire sfbi_cmd_t  CMD,
  // Link side
  input wire logic       SCK,
  input wire logic       CS_N,
  input wire logic       SI,
  input wire logic       SO,
  input wire logic       SO_OE
);
  logic [11:0] bit_cnt_r;
  logic [7:0]  op_r;
  logic        so_rise_r;
  logic [11:0] hdr_bits;

  // ==========================================================
  // Helper logic
  // Select high clears the count, just as it clears the link logic
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      bit_cnt_r <= 12'h000;
      op_r      <= 8'h00;
    end
    else
    begin
      if (bit_cnt_r < 12'h008)
        op_r <= {op_r[6:0], SI};
      // Saturate below the unknown-opcode length so it is never reached
      if (bit_cnt_r != 12'hFFE)
        bit_cnt_r <= bit_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge SCK)
    so_rise_r <= SO;

  always_comb
  begin
    case (op_r)
      OP_RD_LEGACY, OP_PAGE_RD:        hdr_bits = 12'h040;
      OP_RD_STD, OP_BUF_RD:            hdr_bits = 12'h028;
      OP_RD_SLOW, OP_BUF_SLOW, OP_PROT_RD,
      OP_LOCK_RD, OP_SEC_RD:           hdr_bits = 12'h020;
      OP_STAT_RD, OP_ID_RD:            hdr_bits = 12'h008;
      default:                         hdr_bits = 12'hFFF;
    endcase
  end

  // ==========================================================
  // Properties
  sequence s_valid_pulse;
    CMD.valid ##1 !CMD.valid;
  endsequence
  property p_cmd_pulse;
    @(posedge CLK) disable iff (RST) CMD.valid |-> s_valid_pulse;
  endproperty
  property p_cmd_hold;
    @(posedge CLK) disable iff (RST) !CMD.valid
      |-> $stable({CMD.cls, CMD.opcode, CMD.page, CMD.offset});
  endproperty
  property p_oe_cs;
    @(posedge CLK) disable iff (RST) CS_N |-> !SO_OE && SO;
  endproperty
  property p_so_hold;
    @(negedge SCK) disable iff (CS_N) SO_OE |-> SO == so_rise_r;
  endproperty
  property p_hdr_quiet;
    @(posedge SCK) disable iff (CS_N) bit_cnt_r < hdr_bits |-> !SO_OE;
  endproperty
  property p_hdr_drive;
    @(posedge SCK) disable iff (CS_N) bit_cnt_r == hdr_bits |-> SO_OE;
  endproperty
  property p_status;
    @(posedge SCK) disable iff (CS_N)
      op_r == OP_STAT_RD && bit_cnt_r >= 12'h008
      |-> SO == STATUS[3'h7 - bit_cnt_r[2:0]];
  endproperty
  property p_id;
    @(posedge SCK) disable iff (CS_N)
      op_r == OP_ID_RD && bit_cnt_r >= 12'h008 && bit_cnt_r < 12'h028
      |-> SO == ID_CODE[12'h027 - bit_cnt_r];
  endproperty

  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command valid lasted more than one cycle");
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command fields changed without valid");
  a_oe_cs: assert property (p_oe_cs)
    else $error("serial output driven while deselected");
  a_so_hold: assert property (p_so_hold)
    else $error("serial output changed in clock high phase");
  a_hdr_quiet: assert property (p_hdr_quiet)
    else $error("serial output driven during header");
  a_hdr_drive: assert property (p_hdr_drive)
    else $error("serial output not driven after header");
  a_status: assert property (p_status)
    else $error("status bit wrong on serial output");
  a_id: assert property (p_id)
    else $error("identification bit wrong on serial output");
endmodule : sfbi_props

bind sfbi_top sfbi_props #(.ID_CODE(ID_CODE)) sfbi_props_inst (.CLK(CLK),
  .RST(RST), .STATUS(STATUS), .CMD(CMD), .SCK(SCK), .CS_N(CS_N), .SI(SI),
  .SO(SO), .SO_OE(SO_OE));

// ===== tb/sfbi_host.sv
// Host link master model: drives clock, select and serial input
`timescale 1ns/1ps
module sfbi_host
  import sfbi_pkg::*;
(
  // Link towards the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  logic oe_seen;

  // host issues reads only, so no page write or rewrite due
  initial
  begin
    sck     = 1'b0;
    cs_n    = 1'b1;
    si      = 1'b0;
    oe_seen = 1'b0;
  end

  // ==========================================================
  // One frame, 30 ns clock; header left aligned, two bytes back
  task automatic frame(input logic [63:0] hdr, input int nh, input int nr,
                       input logic m3, output logic [15:0] rd);
    oe_seen = 1'b0;
    rd      = 16'h0000;
    // idle level at select gives the mode
    sck = m3;
    #5 cs_n = 1'b0;
    si = hdr[63];
    #15 sck = 1'b0;
    // launch on rising, most significant first
    for (int i = 1; i <= 8 * nh; i++)
    begin
      #15 sck = 1'b1;
      // Released line shows the inverse so a stale value cannot pass
      #1 si = (i < 8 * nh) ? hdr[63 - i] : ~si;
      #14 sck = 1'b0;
    end
    // capture one full period later, just before the fall
    for (int i = 0; i < 8 * nr; i++)
    begin
      #15 sck = 1'b1;
      #15 oe_seen = oe_seen | so_oe;
      rd = {rd[14:0], so_oe ? so : ~so};
      sck = 1'b0;
    end
    #15 sck = m3;
    #15 cs_n = 1'b1;
  endtask : frame
endmodule : sfbi_host

// ===== tb/sfbi_tb_top.sv
// Self-checking bench of the serial flash link front end
`timescale 1ns/1ps
module sfbi_tb_top
  import sfbi_pkg::*;
;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VAL = 32'hC3A51E07;
  localparam logic [7:0] OPS [12] = '{OP_RD_LEGACY, OP_RD_STD, OP_RD_SLOW,
    OP_PAGE_RD, OP_BUF_RD, OP_BUF_SLOW, OP_PROT_RD, OP_LOCK_RD, OP_SEC_RD,
    OP_STAT_RD, OP_ID_RD, 8'h55};
  localparam int HL [12] = '{8, 5, 4, 8, 5, 4, 4, 4, 4, 1, 1, 4};
  localparam sfbi_class_t CLS [12] = '{CL_ARRAY, CL_ARRAY, CL_ARRAY, CL_PAGE,
    CL_BUFFER, CL_BUFFER, CL_PROT, CL_LOCK, CL_SEC, CL_STATUS, CL_ID, CL_NONE};
  logic       clk, rst, page_264, sck, cs_n, si, so, so_oe;
  logic [7:0] status;
  sfbi_fill_t fill;
  sfbi_cmd_t  cmd, last_cmd;
  int         n_mismatch, tests_run, n_cmd;

  sfbi_top #(.ID_CODE(ID_VAL)) sfbi_top_inst (.CLK(clk), .RST(rst), .SCK(sck),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .PAGE_264(page_264),
    .STATUS(status), .FILL(fill), .CMD(cmd));
  sfbi_host sfbi_host_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (cmd.valid === 1'b1)
    begin
      last_cmd <= cmd;
      n_cmd    <= n_cmd + 1;
    end
  end

  function automatic logic [7:0] pimg(input logic [8:0] a);
    return a[7:0] ^ {3'h0, a[8], 4'h0} ^ 8'h5A;
  endfunction : pimg

  function automatic logic [7:0] rimg(input logic [7:0] a);
    return ~a ^ 8'h0F;
  endfunction : rimg

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("cmd_valid", 16'h0000, {15'h0000, cmd.valid});
    check("so_oe", 16'h0000, {15'h0000, so_oe});
    check("so", 16'h0001, {15'h0000, so});
  endtask : t_reset

  task automatic t_fill();
    for (int i = 0; i < 520; i++)
    begin
      @(posedge clk);
      fill <= '{en: 1'b1, region: (i >= 264),
        addr: (i >= 264) ? 9'(i - 264) : 9'(i),
        data: (i >= 264) ? rimg(8'(i - 264)) : pimg(9'(i))};
    end
    @(posedge clk);
    fill.en <= 1'b0;
  endtask : t_fill

  // Every opcode, clock mode picked by its index (odd high, even low), last offset of a page so reads wrap
  task automatic t_ops(input logic p);
    logic [15:0] rd, ex;
    logic [8:0]  off;
    int          n0;
    @(posedge clk);
    page_264 <= p;
    status   <= p ? 8'hC6 : 8'h39;
    repeat (4) @(posedge clk);
    off = p ? 9'h107 : 9'h0FF;
    for (int i = 0; i < 12; i++)
    begin
      n0 = n_cmd;
      #7;
      // Page 3 at the last offset: addr[17:9] and addr[8:0] for 264 bytes
      sfbi_host_inst.frame({OPS[i], p ? 24'h000707 : 24'h0003FF, 32'h0},
                           HL[i], 2, i[0], rd);
      case (CLS[i])
        CL_PROT:   ex = {rimg(8'h00), rimg(8'h01)};
        CL_LOCK:   ex = {rimg(8'h40), rimg(8'h41)};
        CL_SEC:    ex = {rimg(8'h80), rimg(8'h81)};
        CL_STATUS: ex = {status, status};
        CL_ID:     ex = ID_VAL[31:16];
        default:   ex = {pimg(off), pimg(9'h000)};
      endcase
      if (CLS[i] == CL_NONE)
        check("oe_seen", 16'h0000, {15'h0000, sfbi_host_inst.oe_seen});
      else
        check("read_data", ex, rd);
      for (int k = 0; k < 8 && n_cmd == n0; k++)
        @(posedge clk);
      check("cmd_count", 16'(n0 + 1), 16'(n_cmd));
      check("cmd_op", {8'h00, OPS[i]}, {8'h00, last_cmd.opcode});
      check("cmd_cls", {12'h000, CLS[i]}, {12'h000, last_cmd.cls});
      if (CLS[i] inside {CL_ARRAY, CL_PAGE, CL_BUFFER, CL_STATUS, CL_ID})
      begin
        ex = (CLS[i] >= CL_STATUS) ? 16'h0000 : {7'h03, off};
        check("cmd_where", ex, {last_cmd.page[6:0], last_cmd.offset});
      end
    end
  endtask : t_ops

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst        = 1'b1;
    page_264   = 1'b0;
    status     = 8'h00;
    fill       = '0;
    n_mismatch = 0;
    tests_run  = 0;
    n_cmd      = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_fill();
    t_ops(1'b0);
    t_ops(1'b1);
    conclude();
  end

  initial
  begin
    #2000000;
    n_mismatch++;
    conclude();
  end
endmodule : sfbi_tb_top
